// ### hdl/sru_pkg.sv
// constants and types of the serial register update controller
// assumes one core clock domain and one serial link clock domain
`default_nettype none
package sru_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 28;
  localparam int          SPAN_W        = 16;
  localparam int          FIXED_WORDS   = 256;
  localparam int          CFG_WORDS     = 512;
  localparam int          SYNC_W        = 3;
  localparam logic [11:0] FIXED_LAST    = 12'h00FF;
  localparam logic [11:0] CFG_BASE      = 12'h0800;
  localparam logic [11:0] ADDR_LINE_SEL = 12'h0017;
  localparam logic [11:0] ADDR_COUNTS   = 12'h0028;
  localparam logic [15:0] PAT_WORDS     = 16'h0030;
  localparam logic [15:0] SEQ_WORDS     = 16'h0028;
  localparam logic [15:0] FLD_WORDS     = 16'h0010;
  // field layout of the count register and the update line register
  localparam int          PAT_LSB       = 0;
  localparam int          SEQ_LSB       = 8;
  localparam int          CNT_W         = 8;
  localparam int          LINE_LSB      = 0;
  localparam int          LINE_W        = 12;
  localparam logic [11:0] LINE_NOW      = 12'h0000;
  // shutter registers that follow the sensor-gate line
  localparam logic [11:0] SGL_FIRST     = 12'h00A0;
  localparam logic [11:0] SGL_LAST      = 12'h00A3;
  localparam logic [27:0] DATA_ZERO     = 28'h000_0000;

  typedef enum logic [1:0] {UPD_IMM, UPD_VS, UPD_SGL} sru_upd_t;
  typedef enum logic {LS_ADDR, LS_DATA} sru_link_t;
  typedef enum logic {LD_IDLE, LD_WAIT} sru_line_t;

  // update class of a fixed-area register
  function automatic sru_upd_t sru_fixed_class(input logic [11:0] a);
    sru_upd_t c;
    c = UPD_VS;
    if (a <= 12'h0003 || a == 12'h0010 || a == 12'h0012 || a == 12'h0013 ||
        a == ADDR_LINE_SEL || a == ADDR_COUNTS) begin
      c = UPD_IMM;
    end else if (a >= SGL_FIRST && a <= SGL_LAST) begin
      c = UPD_SGL;
    end
    return c;
  endfunction
endpackage
`default_nettype wire

// ### hdl/sru_ctrl.sv
// serial register port with staged register updates
// assumes ser_clk runs only inside frames and vertical/horizontal sync come from pins
`default_nettype none
module sru_ctrl
  import sru_pkg::*;
(
  input  wire logic        ref_clk,                  // core clock
  input  wire logic        nrst,                     // async reset, active low
  input  wire logic        ser_clk,                  // serial link clock
  input  wire logic        ser_sel_n,                // frame select, active low
  input  wire logic        ser_data,                 // serial data in
  input  wire logic        vertical_sync,            // pin, falling edge used
  input  wire logic        horizontal_sync,          // pin, falling edge used
  input  wire logic        sensor_gate_line_start,   // core pulse at sensor-gate line
  input  wire logic        sequence_change_position, // core pulse at change position
  input  wire logic [7:0]  scp_sequence,             // sequence used after the change
  input  wire logic [11:0] rd_addr,                  // read address of applied values
  output logic      [27:0] rd_data_q,                // applied value, one cycle later
  output logic      [15:0] sequence_start_q,         // computed sequence start address
  output logic      [15:0] field_start_q,            // computed field start address
  output logic             vs_apply_q                // pulse when vertical updates apply
);
  // ----------------------------------------------------------------
  // link domain shift logic
  // ----------------------------------------------------------------
  sru_link_t        lstate_q;
  logic [4:0]       bit_cnt_q;
  logic [27:0]      shift_q;
  logic [27:0]      shift_d;
  logic [11:0]      waddr_q;
  logic [27:0]      hold_data_q;
  logic [11:0]      hold_addr_q;
  logic             hold_tog_q;
  logic             link_rst_n;
  logic             word_done;

  // a deasserted select clears the frame state, so a cut word is lost
  assign link_rst_n = nrst & ~ser_sel_n;
  assign shift_d    = {ser_data, shift_q[DATA_W-1:1]};
  assign word_done  = (lstate_q == LS_DATA) && (bit_cnt_q == 5'(DATA_W - 1));

  always_ff @(posedge ser_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lstate_q  <= LS_ADDR;
      bit_cnt_q <= '0;
      shift_q   <= DATA_ZERO;
      waddr_q   <= '0;
    end else begin
      shift_q <= shift_d;
      case (lstate_q)
        LS_ADDR: begin
          if (bit_cnt_q == 5'(ADDR_W - 1)) begin
            waddr_q   <= shift_d[DATA_W-1 -: ADDR_W];
            bit_cnt_q <= '0;
            lstate_q  <= LS_DATA;
          end else begin
            bit_cnt_q <= bit_cnt_q + 5'd1;
          end
        end
        LS_DATA: begin
          if (word_done) begin
            bit_cnt_q <= '0;
            waddr_q   <= waddr_q + 12'h001;
          end else begin
            bit_cnt_q <= bit_cnt_q + 5'd1;
          end
        end
        default: begin
          lstate_q  <= LS_ADDR;
          bit_cnt_q <= '0;
        end
      endcase
    end
  end

  // holding word stays put for 28 link clocks, far longer than the crossing
  always_ff @(posedge ser_clk or negedge nrst) begin
    if (!nrst) begin
      hold_data_q <= DATA_ZERO;
      hold_addr_q <= '0;
      hold_tog_q  <= 1'b0;
    end else if (word_done && !ser_sel_n) begin
      hold_data_q <= shift_d;
      hold_addr_q <= waddr_q;
      hold_tog_q  <= ~hold_tog_q;
    end
  end

  // ----------------------------------------------------------------
  // crossing and pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0]       sync_q [SYNC_W];
  logic             wr_ev;
  logic             vs_fall;
  logic             hs_fall;
  logic             wr_stb_q;
  logic [11:0]      wr_addr_q;
  logic [27:0]      wr_data_q;

  // reset value of the toggle stage matches the link toggle after release,
  // so no false write strobe follows reset; sync pins idle high
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int s = 0; s < SYNC_W; s++) begin
        sync_q[s] <= {1'b0, 1'b1, 1'b1};
      end
    end else begin
      sync_q[0] <= {hold_tog_q, vertical_sync, horizontal_sync};
      sync_q[1] <= sync_q[0];
      sync_q[2] <= sync_q[1];
    end
  end

  // events count while the second and third stages differ after a change
  assign wr_ev   = sync_q[1][2] ^ sync_q[2][2];
  assign vs_fall = !sync_q[1][1] && sync_q[2][1];
  assign hs_fall = !sync_q[1][0] && sync_q[2][0];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_stb_q  <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= DATA_ZERO;
    end else begin
      wr_stb_q <= wr_ev;
      if (wr_ev) begin
        wr_addr_q <= hold_addr_q;
        wr_data_q <= hold_data_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [27:0]      fx_act_q  [FIXED_WORDS];
  logic [27:0]      fx_sh_q   [FIXED_WORDS];
  logic             fx_pend_q [FIXED_WORDS];
  logic [27:0]      cf_act_q  [CFG_WORDS];
  logic [27:0]      cf_sh_q   [CFG_WORDS];
  logic             cf_pend_q [CFG_WORDS];
  logic [11:0]      line_sel;
  logic [15:0]      pat_span;
  logic [15:0]      seq_span;
  logic [15:0]      scp_lo;
  logic [15:0]      scp_hi;
  logic [11:0]      cf_off;
  logic             wr_fixed;
  logic             wr_cfg;
  logic             commit_vs;

  assign line_sel = fx_act_q[ADDR_LINE_SEL[7:0]][LINE_LSB +: LINE_W];
  assign pat_span = SPAN_W'(fx_act_q[ADDR_COUNTS[7:0]][PAT_LSB +: CNT_W]) * PAT_WORDS;
  assign seq_span = SPAN_W'(fx_act_q[ADDR_COUNTS[7:0]][SEQ_LSB +: CNT_W]) * SEQ_WORDS;
  assign scp_lo   = pat_span + SPAN_W'(scp_sequence) * SEQ_WORDS;
  assign scp_hi   = scp_lo + SEQ_WORDS;
  assign cf_off   = wr_addr_q - CFG_BASE;
  assign wr_fixed = wr_stb_q && (wr_addr_q <= FIXED_LAST);
  assign wr_cfg   = wr_stb_q && (wr_addr_q >= CFG_BASE) &&
                    (SPAN_W'(cf_off) < SPAN_W'(CFG_WORDS));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < FIXED_WORDS; i++) begin
        fx_act_q[i]  <= DATA_ZERO;
        fx_sh_q[i]   <= DATA_ZERO;
        fx_pend_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < FIXED_WORDS; i++) begin
        if (fx_pend_q[i]) begin
          case (sru_fixed_class(12'(i)))
            UPD_VS: begin
              if (commit_vs) begin
                fx_act_q[i]  <= fx_sh_q[i];
                fx_pend_q[i] <= 1'b0;
              end
            end
            UPD_SGL: begin
              if (sensor_gate_line_start) begin
                fx_act_q[i]  <= fx_sh_q[i];
                fx_pend_q[i] <= 1'b0;
              end
            end
            default: begin
              fx_pend_q[i] <= 1'b0;
            end
          endcase
        end
      end
      // a new write wins over a commit in the same cycle
      if (wr_fixed) begin
        if (sru_fixed_class(wr_addr_q) == UPD_IMM) begin
          fx_act_q[wr_addr_q[7:0]] <= wr_data_q;
        end else begin
          fx_sh_q[wr_addr_q[7:0]]   <= wr_data_q;
          fx_pend_q[wr_addr_q[7:0]] <= 1'b1;
        end
      end
    end
  end

  // pattern groups all apply at a change, being referenced by any sequence
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int j = 0; j < CFG_WORDS; j++) begin
        cf_act_q[j]  <= DATA_ZERO;
        cf_sh_q[j]   <= DATA_ZERO;
        cf_pend_q[j] <= 1'b0;
      end
    end else begin
      for (int j = 0; j < CFG_WORDS; j++) begin
        if (cf_pend_q[j]) begin
          if (SPAN_W'(j) < pat_span) begin
            if (sequence_change_position) begin
              cf_act_q[j]  <= cf_sh_q[j];
              cf_pend_q[j] <= 1'b0;
            end
          end else if (SPAN_W'(j) < pat_span + seq_span) begin
            if (sequence_change_position && SPAN_W'(j) >= scp_lo &&
                SPAN_W'(j) < scp_hi) begin
              cf_act_q[j]  <= cf_sh_q[j];
              cf_pend_q[j] <= 1'b0;
            end
          end else if (vs_fall) begin
            cf_act_q[j]  <= cf_sh_q[j];
            cf_pend_q[j] <= 1'b0;
          end
        end
      end
      if (wr_cfg) begin
        cf_sh_q[cf_off[8:0]]   <= wr_data_q;
        cf_pend_q[cf_off[8:0]] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // postponed vertical update
  // ----------------------------------------------------------------
  sru_line_t        lnst_q;
  logic [11:0]      line_cnt_q;
  logic [11:0]      line_cnt_inc;

  assign line_cnt_inc = line_cnt_q + 12'h001;
  assign commit_vs    = (vs_fall && line_sel == LINE_NOW) ||
                        (lnst_q == LD_WAIT && hs_fall && line_cnt_inc == line_sel);

  // a new vertical edge restarts the line count of a pending delay
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lnst_q     <= LD_IDLE;
      line_cnt_q <= '0;
    end else begin
      case (lnst_q)
        LD_IDLE: begin
          if (vs_fall && line_sel != LINE_NOW) begin
            lnst_q     <= LD_WAIT;
            line_cnt_q <= '0;
          end
        end
        LD_WAIT: begin
          if (vs_fall) begin
            line_cnt_q <= '0;
          end else if (hs_fall) begin
            line_cnt_q <= line_cnt_inc;
            if (line_cnt_inc == line_sel) begin
              lnst_q <= LD_IDLE;
            end
          end
        end
        default: begin
          lnst_q <= LD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [11:0]      rd_off;

  assign rd_off = rd_addr - CFG_BASE;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q        <= DATA_ZERO;
      sequence_start_q <= '0;
      field_start_q    <= '0;
      vs_apply_q       <= 1'b0;
    end else begin
      if (rd_addr <= FIXED_LAST) begin
        rd_data_q <= fx_act_q[rd_addr[7:0]];
      end else if (rd_addr >= CFG_BASE && SPAN_W'(rd_off) < SPAN_W'(CFG_WORDS)) begin
        rd_data_q <= cf_act_q[rd_off[8:0]];
      end else begin
        rd_data_q <= DATA_ZERO;
      end
      sequence_start_q <= SPAN_W'(CFG_BASE) + pat_span;
      field_start_q    <= SPAN_W'(CFG_BASE) + pat_span + seq_span;
      vs_apply_q       <= commit_vs;
    end
  end
endmodule
`default_nettype wire

// ### bench/sru_ctrl_monitor.sv
// port checker of the serial register update controller
// assumes it is bound to sru_ctrl; only the core clock domain is checked
`default_nettype none
module sru_ctrl_monitor
  import sru_pkg::*;
(
  input wire logic        ref_clk,          // core clock
  input wire logic        nrst,             // async reset, active low
  input wire logic        ser_clk,          // link clock
  input wire logic        vertical_sync,    // sync pin
  input wire logic        horizontal_sync,  // sync pin
  input wire logic [11:0] rd_addr,          // read address
  input wire logic [27:0] rd_data_q,        // applied value
  input wire logic [15:0] sequence_start_q, // sequence start
  input wire logic [15:0] field_start_q,    // field start
  input wire logic        vs_apply_q        // vertical apply pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ----
  // helpers
  // ----
  // live_q masks the first edge after reset, where outputs still hold 0
  logic       live_q;
  logic [3:0] quiet_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) live_q <= 1'b0;
    else live_q <= 1'b1;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) quiet_q <= 4'h0;
    else if ($changed(vertical_sync) || $changed(horizontal_sync)) quiet_q <= 4'h0;
    else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
  end
  a_vs_single: assert property (vs_apply_q |=> !vs_apply_q)
    else $error("vertical apply pulse too long");
  a_vs_near_sync: assert property (vs_apply_q |-> quiet_q < 4'h9)
    else $error("vertical apply without a sync fall");
  a_gap_reads_zero: assert property (rd_addr inside {[12'h100:12'h7FF]} |=> rd_data_q == 0)
    else $error("unmapped fixed address reads nonzero");
  a_top_reads_zero: assert property (rd_addr >= 12'hA00 |=> rd_data_q == 0)
    else $error("address above the area reads nonzero");
  a_seq_step: assert property (live_q |-> (16'(sequence_start_q - 16'h0800) % 16'h0030) == 0)
    else $error("sequence start not a pattern multiple");
  a_field_step: assert property (live_q && $stable(sequence_start_q) |->
    field_start_q >= sequence_start_q && ((field_start_q - sequence_start_q) % 16'h0028) == 0)
    else $error("field start not a sequence multiple");
  a_start_bounds: assert property (live_q |-> sequence_start_q <= 16'h37D0 &&
    field_start_q <= sequence_start_q + 16'h27D8)
    else $error("start address beyond the count range");
  a_start_release: assert property ($rose(live_q) |->
    sequence_start_q == 16'h0800 && field_start_q == 16'h0800)
    else $error("start addresses wrong after reset");
endmodule
bind sru_ctrl sru_ctrl_monitor u_mon (.ref_clk, .nrst, .ser_clk, .vertical_sync,
  .horizontal_sync, .rd_addr, .rd_data_q, .sequence_start_q, .field_start_q, .vs_apply_q);
`default_nettype wire

// ### bench/sru_host.sv
// host model driving the three-wire register port
// assumes the bench calls send; the link clock stands low between frames
`default_nettype none
module sru_host (
  output logic ser_clk,   // link clock, 64 ns
  output logic ser_sel_n, // frame select, active low
  output logic ser_data   // serial data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ser_clk = 1'b0;
    ser_sel_n = 1'b1;
    ser_data = 1'b0;
  end
  task automatic put(input logic b);
    ser_data = b;
    #32 ser_clk = 1'b1;
    #32 ser_clk = 1'b0;
  endtask
  // ----
  // frame
  // ----
  // a nonzero cut drops that many top bits of the last word
  task automatic send(input logic [11:0] a, input logic [27:0] w[$], input int cut);
    #3 ser_sel_n = 1'b0;
    for (int i = 0; i < 12; i++) put(a[i]);
    foreach (w[k])
      for (int i = 0; i < 28 - (k == w.size() - 1 ? cut : 0); i++) put(w[k][i]);
    #32 ser_sel_n = 1'b1;
    ser_data = ~ser_data; // released line must not keep a usable level
  endtask
endmodule
`default_nettype wire

// ### bench/sru_ctrl_test.sv
// self-checking bench of the serial register update controller
// assumes sru_host drives the link and the port checker is bound
`default_nettype none
module sru_ctrl_test
  import sru_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 0, nrst = 0, vertical_sync = 1, horizontal_sync = 1;
  logic        sensor_gate_line_start = 0, sequence_change_position = 0;
  logic [7:0]  scp_sequence = 0, p, s;
  logic [11:0] rd_addr = 0, a;
  logic [11:0] bad [3] = '{12'h100, 12'h7FF, 12'hA00};
  wire         ser_clk, ser_sel_n, ser_data;
  logic [27:0] rd_data_q, v, w;
  logic [15:0] sequence_start_q, field_start_q;
  logic        vs_apply_q;
  int          errors = 0, samples_checked = 0, vs_seen = 0, n;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (vs_apply_q === 1'b1) vs_seen++;
  sru_host u_host (.ser_clk, .ser_sel_n, .ser_data);
  sru_ctrl u_dut (.ref_clk, .nrst, .ser_clk, .ser_sel_n, .ser_data, .vertical_sync,
    .horizontal_sync, .sensor_gate_line_start, .sequence_change_position, .scp_sequence,
    .rd_addr, .rd_data_q, .sequence_start_q, .field_start_q, .vs_apply_q);
  // ----
  // helpers
  // ----
  function automatic logic [15:0] fstart(input logic [7:0] pc, input logic [7:0] sc);
    return 16'h0800 + 16'(pc) * 16'h0030 + 16'(sc) * 16'h0028;
  endfunction
  task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [11:0] ad, input logic [27:0] e, input string nm);
    @(negedge ref_clk) rd_addr = ad;
    @(negedge ref_clk);
    chk(nm, e, rd_data_q);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [27:0] d[$], input int cut);
    u_host.send(ad, d, cut);
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic sync_fall(input bit h);
    @(negedge ref_clk);
    if (h) horizontal_sync = 0;
    else vertical_sync = 0;
    repeat (10) @(negedge ref_clk);
    horizontal_sync = 1;
    vertical_sync = 1;
    repeat (10) @(negedge ref_clk);
  endtask
  task automatic pulse(input bit g);
    @(negedge ref_clk);
    if (g) sensor_gate_line_start = 1;
    else sequence_change_position = 1;
    @(negedge ref_clk);
    sensor_gate_line_start = 0;
    sequence_change_position = 0;
  endtask
  task automatic complete_run();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    v = 28'($urandom(10));
    repeat (2) @(negedge ref_clk);
    nrst = 1;
    repeat (4) @(negedge ref_clk);
    rd(ADDR_LINE_SEL, DATA_ZERO, "line reg");
    v = 28'($urandom);
    w = 28'($urandom);
    wr(12'h000, {v, 28'hFFF_FFFF, w, DATA_ZERO}, 0);
    rd(12'h000, v, "imm 0");
    rd(12'h001, 28'hFFF_FFFF, "imm 1");
    rd(12'h002, w, "imm 2");
    wr(12'h012, {w, v}, 0);
    rd(12'h013, v, "auto 13");
    wr(12'h013, {~v}, 1);
    rd(12'h013, v, "short");
    wr(12'h004, {w}, 0);
    rd(12'h004, DATA_ZERO, "vs held");
    n = vs_seen;
    sync_fall(0);
    chk("vs pulse", 28'(n + 1), 28'(vs_seen));
    rd(12'h004, w, "vs apply");
    wr(ADDR_LINE_SEL, {28'h000_0002}, 0);
    wr(12'h005, {v}, 0);
    wr(CFG_BASE, {w}, 0);
    sync_fall(0);
    rd(12'h005, DATA_ZERO, "line held");
    rd(CFG_BASE, w, "field vs");
    sync_fall(1);
    sync_fall(1);
    rd(12'h005, v, "line apply");
    wr(ADDR_LINE_SEL, {DATA_ZERO}, 0);
    p = 8'($urandom_range(4, 1));
    s = 8'($urandom_range(4, 1));
    wr(ADDR_COUNTS, {{12'h000, s, p}}, 0);
    chk("seq start", 28'(fstart(p, 8'h00)), 28'(sequence_start_q));
    chk("field start", 28'(fstart(p, s)), 28'(field_start_q));
    a = 12'(fstart(p, s - 8'h01));
    wr(12'h801, {v}, 0);
    wr(12'h801, {~v}, 0);
    wr(a, {w}, 0);
    scp_sequence = s;
    pulse(0);
    rd(12'h801, ~v, "last wins");
    rd(a, DATA_ZERO, "seq unused");
    scp_sequence = s - 8'h01;
    pulse(0);
    rd(a, w, "seq used");
    wr(SGL_FIRST, {v}, 0);
    sync_fall(0);
    rd(SGL_FIRST, DATA_ZERO, "sg held");
    pulse(1);
    rd(SGL_FIRST, v, "sg apply");
    foreach (bad[i]) begin
      wr(bad[i], {v}, 0);
      rd(bad[i], DATA_ZERO, "unmapped");
    end
    complete_run();
  end
  initial begin
    // about six times the length of all scenarios together
    #300_000;
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
